// >>> pkg/cpm_pkg.sv
// Package for the core programming model register file.
// Assumes one 100 MHz core clock and a synchronous active-high reset.
package cpm_pkg;
  // Condition flag bit positions.
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_OVERFLOW = 1;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_NEGATIVE = 3;
  localparam int FLAG_EXTEND = 4;
  localparam int FLAG_PREDICT = 7;
  // Writable condition flag bits; bits 6 and 5 are held at zero.
  localparam logic [7:0] FLAG_WRITE_MASK = 8'h9F;
  // Status word fields and reset value of the system byte.
  localparam int STAT_PRIV_BIT = 13;
  localparam logic [7:0] STAT_SYS_MASK = 8'hB7;
  localparam logic [7:0] STAT_SYS_RESET = 8'h27;
  // Control register select codes for the move control instruction.
  localparam logic [11:0] SEL_CACHE_CONTROL = 12'h002;
  localparam logic [11:0] SEL_ACCESS_CONTROL_0 = 12'h004;
  localparam logic [11:0] SEL_ACCESS_CONTROL_1 = 12'h005;
  localparam logic [11:0] SEL_VECTOR_TABLE_BASE = 12'h801;
  localparam logic [11:0] SEL_SRAM_BASE_ADDRESS = 12'hC04;
  localparam logic [11:0] SEL_PERIPH_BASE_ADDRESS = 12'hC0F;
  // Vector table base: low 20 bits are not implemented.
  localparam logic [31:0] VBR_MASK = 32'hFFF0_0000;
  // Address of the reset vector holding the initial stack pointer.
  localparam logic [31:0] RESET_SP_VECTOR = 32'h0000_0000;
  // Operand sizes.
  typedef enum logic [1:0] {CPM_SZ_BYTE, CPM_SZ_WORD, CPM_SZ_LONG} cpm_size_e;
  // Stack pointer actions.
  typedef enum logic [2:0] {
    CPM_STK_NONE, CPM_STK_CALL, CPM_STK_RET, CPM_STK_EXC, CPM_STK_RTE
  } cpm_stack_e;
  // Program counter step per sequential instruction word.
  localparam logic [31:0] PC_WORD_STEP = 32'h0000_0002;
  localparam logic [31:0] LONG_STEP = 32'h0000_0004;
endpackage

// >>> hw/cpm_flag_gen.sv
// Condition flag generator: negative, zero, overflow, carry and extend.
// Assumes combinational use by the register file on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cpm_flag_gen
  import cpm_pkg::*;
(
  input wire logic [31:0] src_a, // First operand.
  input wire logic [31:0] src_b, // Second operand.
  input wire logic [31:0] result, // Operation result.
  input wire cpm_size_e size, // Operand size.
  input wire logic is_sub, // High for subtraction.
  input wire logic [4:0] old_flags, // Present X N Z V C.
  input wire logic arith, // High when flags come from arithmetic.
  output logic [4:0] new_flags // New X N Z V C.
);
  logic msb_a, msb_b, msb_r, carry, ovf, zero;
  // Pick the most significant bits and the zero test for the size.
  always_comb begin
    unique case (size)
      CPM_SZ_BYTE: begin
        msb_a = src_a[7];
        msb_b = src_b[7];
        msb_r = result[7];
        zero = (result[7:0] == 8'h00);
      end
      CPM_SZ_WORD: begin
        msb_a = src_a[15];
        msb_b = src_b[15];
        msb_r = result[15];
        zero = (result[15:0] == 16'h0000);
      end
      default: begin
        msb_a = src_a[31];
        msb_b = src_b[31];
        msb_r = result[31];
        zero = (result == 32'h0000_0000);
      end
    endcase
    // Carry out of the msb on addition, borrow on subtraction.
    carry = is_sub ? ((msb_b & ~msb_a) | (msb_r & ~msb_a) | (msb_b & msb_r))
                   : ((msb_a & msb_b) | (msb_a & ~msb_r) | (msb_b & ~msb_r));
    // Overflow when the signed result cannot be represented.
    ovf = is_sub ? ((msb_a ^ msb_b) & (msb_r ^ msb_a))
                 : (~(msb_a ^ msb_b) & (msb_r ^ msb_a));
    new_flags[3] = msb_r;
    new_flags[2] = zero;
    new_flags[1] = arith ? ovf : 1'b0;
    new_flags[0] = arith ? carry : 1'b0;
    // Extend follows carry for arithmetic, otherwise is left alone.
    new_flags[4] = arith ? carry : old_flags[4];
  end
endmodule
`default_nettype wire

// >>> hw/cpm_regfile.sv
// Programming model register file of the processor core.
// Assumes the execute pipeline drives one request of each kind per cycle.
// Summary of operation
// - Flag bit 7 selects forward branch prediction.
// - Extend flag takes carry after arithmetic.
// - Negative flag copies result msb.
// - Zero flag set on zero result.
// - Overflow flag set on signed overflow.
// - Carry flag set on carry or borrow.
// - Privilege bit gates supervisor register access.
// - Stack pointer loads from reset vector.
// - One stack pointer shared, word and longword.
// - Call pushes, return pops program counter.
// - Exceptions push status and counter; return restores.
// - Counter steps sequentially, loads on flow change.
// - Move control decodes six select codes.
// - Eight data registers, bit to longword access.
// - Seven address registers, word or longword only.
// - Sixteen bit mask for multiply operand addresses.
// - Eight bit multiply status register held.
// - Debug writes via serial channel or supervisor.
// - Status bit 13 is the privilege state.
// - Flag word access: upper byte zero, ignored.
`timescale 1ns/1ps
`default_nettype none
module cpm_regfile
  import cpm_pkg::*;
#(
  parameter int NUM_DATA = 8, // Number of data registers.
  parameter int NUM_ADDR = 7 // Number of general address registers.
) (
  input wire logic core_clk, // Core clock.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic reset_vec_valid, // Reset vector word fetched from 0x0.
  input wire logic [31:0] reset_vec_data, // Initial stack pointer value.
  input wire logic [2:0] data_rd_sel, // Data register read select.
  output logic [31:0] data_rd_val, // Data register read value.
  input wire logic data_wr_en, // Data register write strobe.
  input wire logic [2:0] data_wr_sel, // Data register write select.
  input wire cpm_size_e data_wr_size, // Data write size.
  input wire logic data_bit_en, // Single bit write.
  input wire logic [4:0] data_bit_pos, // Bit position for bit writes.
  input wire logic [31:0] data_wr_val, // Data write value.
  input wire logic [2:0] addr_rd_sel, // Address register read select, 7 is stack.
  output logic [31:0] addr_rd_val, // Address register read value.
  input wire logic addr_wr_en, // Address register write strobe.
  input wire logic [2:0] addr_wr_sel, // Address register write select, 7 is stack.
  input wire cpm_size_e addr_wr_size, // Address write size, byte treated as word.
  input wire logic [31:0] addr_wr_val, // Address write value.
  input wire cpm_stack_e stack_op, // Implicit stack action.
  input wire logic [31:0] stack_pop_pc, // Counter popped from stack.
  input wire logic [15:0] stack_pop_status, // Status popped from stack.
  output logic [31:0] stack_push_addr, // Address of the next push.
  output logic [31:0] stack_pointer_register, // Shared stack pointer.
  output logic [31:0] instruction_pointer, // Program counter.
  input wire logic pc_advance, // Sequential step strobe.
  input wire logic [31:0] pc_step, // Bytes to step.
  input wire logic pc_load, // Change of flow strobe.
  input wire logic [31:0] pc_target, // Change of flow target.
  output logic [31:0] pc_rel_base, // Base for counter-relative operands.
  input wire logic flag_upd, // Update flags from a result.
  input wire logic flag_arith, // Result came from arithmetic.
  input wire logic flag_sub, // Result came from subtraction.
  input wire cpm_size_e flag_size, // Operand size of the result.
  input wire logic [31:0] flag_src_a, // First operand.
  input wire logic [31:0] flag_src_b, // Second operand.
  input wire logic [31:0] flag_result, // Result value.
  input wire logic status_wr_en, // Move to status word strobe.
  input wire logic [15:0] status_wr_val, // Status word write value.
  output logic [15:0] status_word, // Status word read value.
  output logic [15:0] condition_flags, // Flag word read value.
  output logic predict_fwd_taken, // Forward branch prediction.
  output logic privilege_select, // High in supervisor mode.
  input wire logic ctl_wr_en, // Move control write strobe.
  input wire logic [11:0] ctl_sel, // Control register select code.
  input wire logic [31:0] ctl_wr_val, // Control register write value.
  output logic [31:0] ctl_rd_val, // Control register read value.
  output logic ctl_fault, // Privilege or unknown select fault.
  output logic [31:0] cache_control, // Cache control register.
  output logic [31:0] access_control_0, // Access control register 0.
  output logic [31:0] access_control_1, // Access control register 1.
  output logic [31:0] vector_table_base, // Vector table base.
  output logic [31:0] sram_base_address, // SRAM base address.
  output logic [31:0] peripheral_base_address, // Peripheral base address.
  input wire logic mask_wr_en, // Multiply mask write strobe.
  input wire logic [15:0] mask_wr_val, // Multiply mask value.
  output logic [15:0] mac_addr_mask, // Multiply operand address mask.
  input wire logic mac_stat_wr_en, // Multiply status write strobe.
  input wire logic [7:0] mac_stat_wr_val, // Multiply status value.
  output logic [7:0] mac_status_flags, // Multiply status register.
  input wire logic dbg_serial_wr, // Debug write from serial channel.
  input wire logic dbg_instr_wr, // Debug write instruction.
  input wire logic [3:0] dbg_sel, // Debug register index.
  input wire logic [31:0] dbg_wr_val, // Debug write value.
  output logic dbg_wr_en, // Accepted debug write strobe.
  output logic dbg_fault // Debug write refused in user mode.
);
  logic [31:0] data_ff [NUM_DATA]; // Data registers.
  logic [31:0] addr_ff [NUM_ADDR]; // General address registers.
  logic [31:0] sp_ff; // Stack pointer.
  logic [31:0] pc_ff; // Program counter.
  logic [7:0] flags_ff; // Condition flag byte.
  logic [7:0] sys_ff; // Status system byte.
  logic [31:0] cache_control_ff, access_control_0_ff, access_control_1_ff, vbr_ff, ramb_ff, peripheral_base_address_ff; // Control registers.
  logic [15:0] mask_ff; // Multiply address mask.
  logic [7:0] mac_status_flags_ff; // Multiply status.
  logic [4:0] nxt_flags; // Generated X N Z V C.
  logic sel_ok; // Select code is known.
  logic [31:0] addr_wr_ext; // Sized address write value.

  // Flag arithmetic in its own module.
  cpm_flag_gen u_flags (
    .src_a(flag_src_a),
    .src_b(flag_src_b),
    .result(flag_result),
    .size(flag_size),
    .is_sub(flag_sub),
    .old_flags(flags_ff[4:0]),
    .arith(flag_arith),
    .new_flags(nxt_flags)
  );

  // Data registers take bit, byte, word or longword writes.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_DATA; i++) data_ff[i] <= 32'h0000_0000;
    end else if (data_wr_en) begin
      if (data_bit_en) begin
        data_ff[data_wr_sel][data_bit_pos] <= data_wr_val[0];
      end else begin
        unique case (data_wr_size)
          CPM_SZ_BYTE: data_ff[data_wr_sel][7:0] <= data_wr_val[7:0];
          CPM_SZ_WORD: data_ff[data_wr_sel][15:0] <= data_wr_val[15:0];
          default: data_ff[data_wr_sel] <= data_wr_val;
        endcase
      end
    end
  end
  assign data_rd_val = data_ff[data_rd_sel];

  // Address registers: word writes sign-extend, whole register changes.
  assign addr_wr_ext = (addr_wr_size == CPM_SZ_LONG) ? addr_wr_val :
    {{16{addr_wr_val[15]}}, addr_wr_val[15:0]};
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_ADDR; i++) addr_ff[i] <= 32'h0000_0000;
    end else if (addr_wr_en && addr_wr_sel != 3'h7) begin
      addr_ff[addr_wr_sel] <= addr_wr_ext;
    end
  end
  assign addr_rd_val = (addr_rd_sel == 3'h7) ? sp_ff : addr_ff[addr_rd_sel];

  // The one stack pointer, shared by both modes.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sp_ff <= RESET_SP_VECTOR;
    end else if (reset_vec_valid) begin
      sp_ff <= reset_vec_data;
    end else if (stack_op == CPM_STK_CALL) begin
      sp_ff <= sp_ff - LONG_STEP;
    end else if (stack_op == CPM_STK_RET) begin
      sp_ff <= sp_ff + LONG_STEP;
    end else if (stack_op == CPM_STK_EXC) begin
      sp_ff <= sp_ff - (LONG_STEP + LONG_STEP);
    end else if (stack_op == CPM_STK_RTE) begin
      sp_ff <= sp_ff + (LONG_STEP + LONG_STEP);
    end else if (addr_wr_en && addr_wr_sel == 3'h7) begin
      sp_ff <= addr_wr_ext;
    end
  end
  assign stack_pointer_register = sp_ff;
  assign stack_push_addr = sp_ff - LONG_STEP;

  // Program counter: step, load, or restore from the stack.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pc_ff <= 32'h0000_0000;
    end else if (stack_op == CPM_STK_RET || stack_op == CPM_STK_RTE) begin
      pc_ff <= stack_pop_pc;
    end else if (pc_load) begin
      pc_ff <= pc_target;
    end else if (pc_advance) begin
      pc_ff <= pc_ff + pc_step;
    end
  end
  assign instruction_pointer = pc_ff;
  assign pc_rel_base = pc_ff + PC_WORD_STEP;

  // Condition flags; user writes reach only the low byte.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flags_ff <= 8'h00;
    end else if (stack_op == CPM_STK_RTE) begin
      flags_ff <= stack_pop_status[7:0] & FLAG_WRITE_MASK;
    end else if (status_wr_en) begin
      flags_ff <= status_wr_val[7:0] & FLAG_WRITE_MASK;
    end else if (flag_upd) begin
      flags_ff[4:0] <= nxt_flags;
    end
  end

  // System byte: only supervisor writes, a return from exception in supervisor, or exception entry change it; reset enters supervisor.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sys_ff <= STAT_SYS_RESET;
    end else if (stack_op == CPM_STK_RTE && privilege_select) begin
      sys_ff <= stack_pop_status[15:8] & STAT_SYS_MASK;
    end else if (status_wr_en && privilege_select) begin
      sys_ff <= status_wr_val[15:8] & STAT_SYS_MASK;
    end else if (stack_op == CPM_STK_EXC) begin
      sys_ff[STAT_PRIV_BIT-8] <= 1'b1;
    end
  end
  assign status_word = {sys_ff, flags_ff};
  assign condition_flags = {8'h00, flags_ff};
  assign predict_fwd_taken = flags_ff[FLAG_PREDICT];
  assign privilege_select = sys_ff[STAT_PRIV_BIT-8];

  // Control registers written by the move control instruction in supervisor.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      {cache_control_ff, access_control_0_ff, access_control_1_ff, vbr_ff, ramb_ff, peripheral_base_address_ff} <= {6{32'h0000_0000}};
    end else if (ctl_wr_en && privilege_select) begin
      unique case (ctl_sel)
        SEL_CACHE_CONTROL: cache_control_ff <= ctl_wr_val;
        SEL_ACCESS_CONTROL_0: access_control_0_ff <= ctl_wr_val;
        SEL_ACCESS_CONTROL_1: access_control_1_ff <= ctl_wr_val;
        SEL_VECTOR_TABLE_BASE: vbr_ff <= ctl_wr_val & VBR_MASK;
        SEL_SRAM_BASE_ADDRESS: ramb_ff <= ctl_wr_val;
        SEL_PERIPH_BASE_ADDRESS: peripheral_base_address_ff <= ctl_wr_val;
        default: cache_control_ff <= cache_control_ff;
      endcase
    end
  end

  // Read mux and select-code check.
  always_comb begin
    sel_ok = 1'b1;
    unique case (ctl_sel)
      SEL_CACHE_CONTROL: ctl_rd_val = cache_control_ff;
      SEL_ACCESS_CONTROL_0: ctl_rd_val = access_control_0_ff;
      SEL_ACCESS_CONTROL_1: ctl_rd_val = access_control_1_ff;
      SEL_VECTOR_TABLE_BASE: ctl_rd_val = vbr_ff;
      SEL_SRAM_BASE_ADDRESS: ctl_rd_val = ramb_ff;
      SEL_PERIPH_BASE_ADDRESS: ctl_rd_val = peripheral_base_address_ff;
      default: begin
        ctl_rd_val = 32'h0000_0000;
        sel_ok = 1'b0;
      end
    endcase
  end
  assign ctl_fault = ctl_wr_en & (~privilege_select | ~sel_ok);
  assign cache_control = cache_control_ff;
  assign access_control_0 = access_control_0_ff;
  assign access_control_1 = access_control_1_ff;
  assign vector_table_base = vbr_ff;
  assign sram_base_address = ramb_ff;
  assign peripheral_base_address = peripheral_base_address_ff;

  // Multiply unit mask and status, open to user mode.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mask_ff <= 16'hFFFF;
      mac_status_flags_ff <= 8'h00;
    end else begin
      if (mask_wr_en) mask_ff <= mask_wr_val;
      if (mac_stat_wr_en) mac_status_flags_ff <= mac_stat_wr_val;
    end
  end
  assign mac_addr_mask = mask_ff;
  assign mac_status_flags = mac_status_flags_ff;

  // Debug writes: serial always, instruction only in supervisor.
  assign dbg_wr_en = dbg_serial_wr | (dbg_instr_wr & privilege_select);
  assign dbg_fault = dbg_instr_wr & ~dbg_serial_wr & ~privilege_select;
endmodule
`default_nettype wire

// >>> test/cpm_regfile_assertions.sv
// Port checker for the register file.
// Bound to cpm_regfile in the testbench top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module cpm_regfile_assertions
  import cpm_pkg::*;
(
  input wire logic core_clk, // Clock.
  input wire logic reset, // Reset.
  input wire logic reset_vec_valid, // Vector strobe.
  input wire logic [31:0] reset_vec_data, // Vector word.
  input wire cpm_stack_e stack_op, // Stack action.
  input wire logic [31:0] stack_pointer_register, // Stack pointer.
  input wire logic flag_upd, // Flag update.
  input wire logic flag_arith, // Arithmetic.
  input wire cpm_size_e flag_size, // Size.
  input wire logic [31:0] flag_result, // Result.
  input wire logic status_wr_en, // Status write.
  input wire logic [15:0] condition_flags, // Flags.
  input wire logic predict_fwd_taken, // Prediction.
  input wire logic privilege_select, // Supervisor.
  input wire logic ctl_wr_en, // Control write.
  input wire logic ctl_fault, // Control fault.
  input wire logic [31:0] vector_table_base // Vector base.
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // A long result reaches the flags unopposed.
  sequence long_upd;
    flag_upd && !status_wr_en && stack_op != CPM_STK_RTE && flag_size == CPM_SZ_LONG;
  endsequence
  // Exception entry with nothing of higher priority.
  sequence exc_entry;
    stack_op == CPM_STK_EXC && !reset_vec_valid && !status_wr_en;
  endsequence
  pred_bit_a: assert property (predict_fwd_taken == condition_flags[7])
    else $error("Prediction differs from flag bit 7.");
  ext_carry_a: assert property (
    long_upd ##0 flag_arith |=> condition_flags[4] == condition_flags[0])
    else $error("Extend flag differs from carry.");
  neg_flag_a: assert property (
    long_upd |=> condition_flags[3] == ($past(flag_result) >= 32'h8000_0000))
    else $error("Negative flag wrong.");
  zero_flag_a: assert property (
    long_upd |=> condition_flags[2] == ($past(flag_result) == 32'h0))
    else $error("Zero flag wrong.");
  flag_zeros_a: assert property (
    condition_flags[15:8] == 8'h00 && condition_flags[6:5] == 2'b00)
    else $error("Reserved flag bits not zero.");
  ctl_refuse_a: assert property (
    ctl_wr_en && !privilege_select |-> ctl_fault ##1 $stable(vector_table_base))
    else $error("User control write not refused.");
  call_push_a: assert property (
    stack_op == CPM_STK_CALL && !reset_vec_valid |=>
    stack_pointer_register == $past(stack_pointer_register) - 32'h4)
    else $error("Call did not push one longword.");
  exc_frame_a: assert property (
    exc_entry |=> privilege_select && stack_pointer_register == $past(stack_pointer_register) - 32'h8)
    else $error("Exception frame wrong.");
  sp_vector_a: assert property (
    reset_vec_valid |=> stack_pointer_register == $past(reset_vec_data))
    else $error("Stack pointer not loaded from vector.");
endmodule
`default_nettype wire

// >>> test/cpm_pipe_model.sv
// Pipeline memory model: reset vector fetch and stack frames.
// Assumes it sees the register file's stack, counter and status outputs.
`timescale 1ns/1ps
`default_nettype none
module cpm_pipe_model
  import cpm_pkg::*;
#(
  parameter int FETCH_WAIT = 3, // Cycles from release to vector.
  parameter logic [31:0] VEC_WORD = 32'h0002_0000 // Word at RESET_SP_VECTOR.
) (
  input wire logic core_clk, // Clock.
  input wire logic reset, // Reset.
  input wire cpm_stack_e stack_op, // Stack action.
  input wire logic [31:0] instruction_pointer, // Counter to save.
  input wire logic [15:0] status_word, // Status to save.
  output logic reset_vec_valid, // Vector word arrives.
  output logic [31:0] reset_vec_data, // Vector word.
  output logic [31:0] stack_pop_pc, // Popped counter.
  output logic [15:0] stack_pop_status // Popped status.
);
  logic [3:0] wait_cnt; // Cycles since release, saturating.
  logic [31:0] saved_pc; // Counter of the newest frame.
  logic [15:0] saved_st; // Status of the newest frame.
  // Delay the vector after reset, as memory would.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wait_cnt <= '0;
    end else if (wait_cnt != 4'hF) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
  assign reset_vec_valid = !reset && wait_cnt == 4'(FETCH_WAIT);
  assign reset_vec_data = reset_vec_valid ? VEC_WORD : ~VEC_WORD;
  // Keep the frame a call or exception pushes.
  always_ff @(posedge core_clk) begin
    if (stack_op == CPM_STK_CALL || stack_op == CPM_STK_EXC) begin
      saved_pc <= instruction_pointer;
      saved_st <= status_word;
    end
  end
  // Pops see the frame; otherwise no stale value shows.
  assign stack_pop_pc = (stack_op inside {CPM_STK_RET, CPM_STK_RTE}) ? saved_pc : ~saved_pc;
  assign stack_pop_status = (stack_op == CPM_STK_RTE) ? saved_st : ~saved_st;
endmodule
`default_nettype wire

// >>> test/test_cpm_regfile.sv
// Self-checking testbench for the register file.
// Assumes package, pipe model and checker compile first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("Error %s expected %h seen %h", nm, e, a); end end
module test_cpm_regfile
  import cpm_pkg::*;
;
  localparam logic [31:0] VEC = 32'h0002_0000; // Initial stack pointer in memory.
  localparam logic [11:0] SEL_TAB [6] = '{SEL_CACHE_CONTROL, SEL_ACCESS_CONTROL_0,
    SEL_ACCESS_CONTROL_1, SEL_VECTOR_TABLE_BASE, SEL_SRAM_BASE_ADDRESS, SEL_PERIPH_BASE_ADDRESS};
  logic core_clk, reset, reset_vec_valid, data_wr_en, data_bit_en, addr_wr_en, pc_advance;
  logic pc_load, flag_upd, flag_arith, flag_sub, status_wr_en, predict_fwd_taken, ctl_fault;
  logic privilege_select, ctl_wr_en, mask_wr_en, mac_stat_wr_en, dbg_serial_wr, dbg_instr_wr;
  logic dbg_wr_en, dbg_fault;
  logic [2:0] data_rd_sel, data_wr_sel, addr_rd_sel, addr_wr_sel;
  logic [4:0] data_bit_pos;
  logic [3:0] dbg_sel;
  logic [7:0] mac_stat_wr_val, mac_status_flags;
  logic [11:0] ctl_sel;
  logic [15:0] stack_pop_status, status_wr_val, status_word, condition_flags;
  logic [15:0] mask_wr_val, mac_addr_mask;
  logic [31:0] reset_vec_data, data_rd_val, data_wr_val, addr_rd_val, addr_wr_val, stack_pop_pc;
  logic [31:0] stack_push_addr, stack_pointer_register, instruction_pointer, pc_step, pc_target;
  logic [31:0] pc_rel_base, flag_src_a, flag_src_b, flag_result, ctl_wr_val, ctl_rd_val;
  logic [31:0] dbg_wr_val, cache_control, access_control_0, access_control_1, vector_table_base;
  logic [31:0] sram_base_address, peripheral_base_address, exp_v;
  cpm_size_e data_wr_size, addr_wr_size, flag_size;
  cpm_stack_e stack_op;
  int bad_count = 0; // Mismatches.
  int num_checks = 0; // Comparisons.
  cpm_regfile dut (.*);
  cpm_pipe_model #(.VEC_WORD(VEC)) pipe (.*);
  // Free-running 100 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Pass an edge, then drop all strobes 1 ns later.
  task automatic tick();
    @(posedge core_clk);
    #1;
    {data_wr_en, data_bit_en, addr_wr_en, pc_advance, pc_load, flag_upd, status_wr_en} = '0;
    {ctl_wr_en, mask_wr_en, mac_stat_wr_en, dbg_serial_wr, dbg_instr_wr} = '0;
    stack_op = CPM_STK_NONE;
  endtask
  // One flag update.
  task automatic flag_op(input logic sb, ar, input cpm_size_e sz, input logic [31:0] a, b, r);
    flag_upd = 1'b1;
    flag_sub = sb;
    flag_arith = ar;
    flag_size = sz;
    flag_src_a = a;
    flag_src_b = b;
    flag_result = r;
    tick();
  endtask
  // Move to status word.
  task automatic wr_status(input logic [15:0] v);
    status_wr_en = 1'b1;
    status_wr_val = v;
    tick();
  endtask
  // Data register write; read select follows.
  task automatic wr_data(input logic [2:0] s, input cpm_size_e sz, input logic bt,
                         input logic [31:0] v);
    data_wr_en = 1'b1;
    data_wr_sel = s;
    data_rd_sel = s;
    data_wr_size = sz;
    data_bit_en = bt;
    data_wr_val = v;
    tick();
  endtask
  // Move control write; select kept for read back.
  task automatic wr_ctl(input logic [11:0] s, input logic [31:0] v);
    ctl_wr_en = 1'b1;
    ctl_sel = s;
    ctl_wr_val = v;
    tick();
  endtask
  // Print counts and verdict, then stop.
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Watchdog: the run needs about 0.5 us.
  initial begin
    #20000;
    bad_count++;
    end_sim();
  end
  // Scenarios.
  initial begin
    reset = 1'b1;
    tick();
    {data_rd_sel, data_wr_sel, addr_rd_sel, addr_wr_sel, dbg_sel, mac_stat_wr_val} = '0;
    {ctl_sel, status_wr_val, mask_wr_val, flag_sub, flag_arith, pc_step, pc_target} = '0;
    {data_wr_val, addr_wr_val, flag_src_a, flag_src_b, flag_result, ctl_wr_val, dbg_wr_val} = '0;
    data_bit_pos = 5'd31;
    flag_size = CPM_SZ_LONG;
    @(posedge core_clk);
    #1;
    reset = 1'b0;
    `CHK("status reset", 16'h2700, status_word);
    `CHK("mask reset", 16'hFFFF, mac_addr_mask);
    repeat (5) tick();
    `CHK("stack vector", VEC, stack_pointer_register);
    flag_op(1'b0, 1'b1, CPM_SZ_BYTE, 32'h7F, 32'h01, 32'h80);
    `CHK("add byte", 16'h000A, condition_flags);
    flag_op(1'b0, 1'b1, CPM_SZ_LONG, 32'hFFFF_FFFF, 32'h1, 32'h0);
    `CHK("carry", 16'h0015, condition_flags);
    flag_op(1'b1, 1'b1, CPM_SZ_LONG, 32'h0, 32'h1, 32'hFFFF_FFFF);
    `CHK("borrow", 16'h0019, condition_flags);
    flag_op(1'b0, 1'b0, CPM_SZ_LONG, 32'h0, 32'h0, 32'h8000_0000);
    `CHK("logic", 16'h0018, condition_flags);
    wr_status(16'h27E0);
    `CHK("flag bits", 16'h0080, condition_flags);
    `CHK("taken", 1'b1, predict_fwd_taken);
    wr_status(16'h2700);
    `CHK("not taken", 1'b0, predict_fwd_taken);
    for (int i = 0; i < 8; i++) begin
      wr_data(3'(i), CPM_SZ_LONG, 1'b0, 32'hD000_0000 + 32'(i));
    end
    wr_data(3'd3, CPM_SZ_BYTE, 1'b0, 32'hFFFF_FFAB);
    `CHK("byte", 32'hD000_00AB, data_rd_val);
    wr_data(3'd3, CPM_SZ_WORD, 1'b0, 32'hFFFF_CDEF);
    wr_data(3'd3, CPM_SZ_LONG, 1'b1, 32'h0);
    `CHK("bit", 32'h5000_CDEF, data_rd_val);
    data_rd_sel = 3'd7;
    #1;
    `CHK("d7", 32'hD000_0007, data_rd_val);
    addr_wr_en = 1'b1;
    addr_wr_sel = 3'd2;
    addr_rd_sel = 3'd2;
    addr_wr_size = CPM_SZ_WORD;
    addr_wr_val = 32'h1234_8000;
    tick();
    `CHK("word addr", 32'hFFFF_8000, addr_rd_val);
    {pc_load, pc_advance} = 2'b11;
    pc_target = 32'h0000_1000;
    pc_step = PC_WORD_STEP;
    tick();
    `CHK("load", 32'h0000_1000, instruction_pointer);
    pc_advance = 1'b1;
    tick();
    `CHK("advance", 32'h0000_1002, instruction_pointer);
    `CHK("rel base", 32'h0000_1004, pc_rel_base);
    `CHK("push addr", VEC - 32'h4, stack_push_addr);
    stack_op = CPM_STK_CALL;
    tick();
    `CHK("call", VEC - 32'h4, stack_pointer_register);
    pc_load = 1'b1;
    pc_target = 32'h0000_2000;
    tick();
    stack_op = CPM_STK_RET;
    tick();
    `CHK("ret pc", 32'h0000_1002, instruction_pointer);
    for (int i = 0; i < 6; i++) begin
      exp_v = 32'h1111_1111 * 32'(i + 1);
      wr_ctl(SEL_TAB[i], exp_v);
      exp_v = (i == 3) ? exp_v & VBR_MASK : exp_v;
      `CHK("control", exp_v, ctl_rd_val);
    end
    `CHK("bases", 64'h4440_0000_6666_6666, {vector_table_base, peripheral_base_address});
    ctl_wr_en = 1'b1;
    ctl_sel = 12'h003;
    #1;
    `CHK("bad select", 1'b1, ctl_fault);
    tick();
    mask_wr_en = 1'b1;
    mask_wr_val = 16'h00F0;
    mac_stat_wr_en = 1'b1;
    mac_stat_wr_val = 8'h5A;
    dbg_instr_wr = 1'b1;
    #1;
    `CHK("dbg super", 1'b1, dbg_wr_en);
    tick();
    `CHK("mask", 16'h00F0, mac_addr_mask);
    `CHK("mac status", 8'h5A, mac_status_flags);
    wr_status(16'h0000);
    `CHK("user", 1'b0, privilege_select);
    wr_ctl(SEL_CACHE_CONTROL, 32'h0);
    `CHK("refused", 32'h1111_1111, cache_control);
    wr_status(16'h2001);
    `CHK("user status", 16'h0001, status_word);
    dbg_instr_wr = 1'b1;
    #1;
    `CHK("dbg user", 1'b1, dbg_fault);
    tick();
    dbg_serial_wr = 1'b1;
    #1;
    `CHK("dbg serial", 1'b1, dbg_wr_en);
    tick();
    stack_op = CPM_STK_EXC;
    tick();
    `CHK("exc sp", VEC - 32'h8, stack_pointer_register);
    `CHK("exc mode", 1'b1, privilege_select);
    pc_load = 1'b1;
    pc_target = 32'h0000_3000;
    tick();
    stack_op = CPM_STK_RTE;
    tick();
    `CHK("rte status", 16'h0001, status_word);
    `CHK("rte pc", 32'h0000_1002, instruction_pointer);
    `CHK("rte sp", VEC, stack_pointer_register);
    end_sim();
  end
endmodule
bind cpm_regfile cpm_regfile_assertions chk (.*);
`default_nettype wire
